// file: src/sqd_pkg.sv
// Shared constants and carriers for the queue descriptor block.
package sqd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Sizes.

	// Register port address and data widths.
	localparam int unsigned SQD_AW = 16;
	localparam int unsigned SQD_DW = 16;
	// Cell address width: a byte address of 25 bits counted in 64-byte cells.
	localparam int unsigned SQD_CELL_AW = 19;
	// Cell payload width carried through the queue path.
	localparam int unsigned SQD_CELL_DW = 32;
	// Number of queues and the first queue of the extended group.
	localparam int unsigned SQD_NQ = 64;
	localparam int unsigned SQD_NQ_BASIC = 32;
	// Depth of the ingress cell FIFO.
	localparam int unsigned SQD_FIFO_DEPTH = 16;

	////////////////////////////////////////////////////////////////////////////////
	// Register map.

	// Definition structures: one 32-byte block per queue.
	localparam logic [15:0] SQD_DEF_BASE = 16'h2000;
	localparam logic [15:0] SQD_DEF_LAST = 16'h27E0;
	localparam logic [15:0] SQD_DEF_STRIDE = 16'h0020;
	// Field offsets inside one definition structure.
	localparam logic [4:0] SQD_OFS_BASE_HI = 5'h00;
	localparam logic [4:0] SQD_OFS_BASE_LO = 5'h02;
	localparam logic [4:0] SQD_OFS_END_HI = 5'h04;
	localparam logic [4:0] SQD_OFS_END_LO = 5'h06;
	localparam logic [4:0] SQD_OFS_WP_HI = 5'h08;
	localparam logic [4:0] SQD_OFS_WP_LO = 5'h0A;
	localparam logic [4:0] SQD_OFS_RP_HI = 5'h0C;
	localparam logic [4:0] SQD_OFS_RP_LO = 5'h0E;
	// Per-queue control words, one 16-bit word per queue.
	localparam logic [15:0] SQD_CTRL_BASE = 16'h0440;
	localparam logic [15:0] SQD_CTRL_LAST = 16'h04BE;
	// Global configuration word holding the extended queue select.
	localparam logic [15:0] SQD_GLOBAL_ADDR = 16'h0400;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values.

	localparam int unsigned SQD_LO_LSB = 13;
	localparam int unsigned SQD_WEN_BIT = 1;
	localparam int unsigned SQD_EMPTY_BIT = 11;
	localparam int unsigned SQD_EXT_SEL_BIT = 0;
	localparam logic [18:0] SQD_PTR_RST = 19'h00000;
	localparam logic SQD_WEN_RST = 1'b0;
	localparam logic SQD_EXT_SEL_RST = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers.

	// A cell waiting to be stored, with its target queue.
	typedef struct packed {
		logic [5:0] queue;
		logic [SQD_CELL_DW-1:0] data;
	} sqd_cell_t;

	// A cell write toward external memory.
	typedef struct packed {
		logic [SQD_CELL_AW-1:0] cell_addr;
		logic [SQD_CELL_DW-1:0] data;
	} sqd_mem_wr_t;

endpackage : sqd_pkg

// file: src/sqd_queue_descriptor.sv
//Contract
// - 64 descriptor structures at 2000h through 27E0h
// - Extended select low keeps queues 32-63 off
// - Base cell from upper and lower fields
// - End cell from upper and lower fields
// - Capacity is end minus base plus one
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Ingress FIFO held in flip-flops.

module sqd_fifo #(
	parameter int unsigned WIDTH = 38,
	parameter int unsigned DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int unsigned PW = $clog2(DEPTH);

	// Storage and pointers; the extra pointer bit tells full from empty.
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW:0] wr_ptr_r;
	logic [PW:0] rd_ptr_r;
	wire logic full = (wr_ptr_r[PW] != rd_ptr_r[PW]) && (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]);
	wire logic empty = (wr_ptr_r == rd_ptr_r);
	wire logic push = i_valid && !full;
	wire logic pop = i_ready && !empty;

	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data = mem_r[rd_ptr_r[PW-1:0]];

	// Storage is not reset; only the pointers decide what is valid.
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wr_ptr_r[PW-1:0]] <= i_data;
		end
	end

	// Pointer update.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_r + (PW+1)'(push);
			rd_ptr_r <= rd_ptr_r + (PW+1)'(pop);
		end
	end
endmodule : sqd_fifo

////////////////////////////////////////////////////////////////////////////////
// Queue descriptor top.

module sqd_queue_descriptor
	import sqd_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = SQD_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_srst,
	// Register port.
	input wire logic [SQD_AW-1:0] i_addr,
	input wire logic [SQD_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [SQD_DW-1:0] o_rdata,
	// Incoming cells.
	input wire logic i_cell_valid,
	output logic o_cell_ready,
	input wire sqd_cell_t i_cell,
	// Cell writes toward external memory.
	output logic o_mem_wr_valid,
	input wire logic i_mem_wr_ready,
	output sqd_mem_wr_t o_mem_wr,
	output logic o_cell_drop,
	// Cell removal requests from the egress side.
	input wire logic i_deq_valid,
	input wire logic [5:0] i_deq_queue,
	output logic o_deq_valid,
	output logic [SQD_CELL_AW-1:0] o_deq_addr,
	output logic o_deq_empty
);
	////////////////////////////////////////////////////////////////////////////////
	// Descriptor state.

	logic [SQD_CELL_AW-1:0] base_r [SQD_NQ]; // Base cell per queue.
	logic [SQD_CELL_AW-1:0] end_r [SQD_NQ]; // Last usable cell per queue.
	logic [SQD_CELL_AW-1:0] wp_r [SQD_NQ]; // Next cell to be written.
	logic [SQD_CELL_AW-1:0] rp_r [SQD_NQ]; // Next cell to be read.
	logic [SQD_NQ-1:0] wen_r; // Per-queue write enable.
	logic [SQD_NQ-1:0] full_r; // Queue holds every cell; pointers then meet as when empty.
	logic ext_sel_r; // Extended queue select.
	logic [SQD_DW-1:0] rdata_r; // Read data, one cycle after the strobe.
	logic mem_valid_r; // Output stage holds a cell write.
	sqd_mem_wr_t mem_wr_r; // Output stage contents.
	logic drop_r; // One-cycle drop pulse.
	logic deq_valid_r; // One-cycle removal answer.
	logic [SQD_CELL_AW-1:0] deq_addr_r; // Cell address of the removal.
	logic deq_empty_r; // One-cycle empty answer.

	////////////////////////////////////////////////////////////////////////////////
	// Address decode.

	// Descriptor window spans the last structure fully.
	wire logic [15:0] def_rel = i_addr - SQD_DEF_BASE;
	wire logic def_hit = (i_addr >= SQD_DEF_BASE) && (i_addr < (SQD_DEF_LAST + SQD_DEF_STRIDE));
	wire logic [5:0] def_q = def_rel[10:5];
	wire logic [4:0] def_fld = def_rel[4:0];
	// Control words sit on even addresses only.
	wire logic [15:0] ctrl_rel = i_addr - SQD_CTRL_BASE;
	wire logic ctrl_hit = (i_addr >= SQD_CTRL_BASE) && (i_addr <= SQD_CTRL_LAST) && !i_addr[0];
	wire logic [5:0] ctrl_q = ctrl_rel[6:1];
	wire logic glob_hit = (i_addr == SQD_GLOBAL_ADDR);
	// Write strobes per field.
	wire logic wr_def = i_wr && def_hit;
	wire logic wr_base_hi = wr_def && (def_fld == SQD_OFS_BASE_HI);
	wire logic wr_base_lo = wr_def && (def_fld == SQD_OFS_BASE_LO);
	wire logic wr_end_hi = wr_def && (def_fld == SQD_OFS_END_HI);
	wire logic wr_end_lo = wr_def && (def_fld == SQD_OFS_END_LO);
	wire logic wr_wp_hi = wr_def && (def_fld == SQD_OFS_WP_HI);
	wire logic wr_wp_lo = wr_def && (def_fld == SQD_OFS_WP_LO);
	wire logic wr_rp_hi = wr_def && (def_fld == SQD_OFS_RP_HI);
	wire logic wr_rp_lo = wr_def && (def_fld == SQD_OFS_RP_LO);
	wire logic [2:0] wr_lo_bits = i_wdata[SQD_LO_LSB+2:SQD_LO_LSB];

	// Queue is usable only when it is inside the active group.
	function automatic logic q_allowed(input logic [5:0] q, input logic ext);
		q_allowed = ext || (q < 6'(SQD_NQ_BASIC));
	endfunction : q_allowed

	// Step a pointer by one cell, returning to base after the end cell.
	function automatic logic [SQD_CELL_AW-1:0] step(input logic [SQD_CELL_AW-1:0] p,
		input logic [SQD_CELL_AW-1:0] b, input logic [SQD_CELL_AW-1:0] e);
		step = (p == e) ? b : p + 19'h00001;
	endfunction : step

	////////////////////////////////////////////////////////////////////////////////
	// Ingress FIFO.

	sqd_cell_t head;
	logic head_valid;
	logic head_pop;

	// The FIFO absorbs bursts while external memory stalls the output stage.
	sqd_fifo #(
		.WIDTH($bits(sqd_cell_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_valid(i_cell_valid),
		.o_ready(o_cell_ready),
		.i_data(i_cell),
		.o_valid(head_valid),
		.i_ready(head_pop),
		.o_data(head)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Enqueue decision.

	wire logic [5:0] hq = head.queue;
	wire logic [SQD_CELL_AW-1:0] hq_wp = wp_r[hq];
	wire logic [SQD_CELL_AW-1:0] hq_wp_nxt = step(hq_wp, base_r[hq], end_r[hq]);
	// All end-base+1 cells are usable, so a flag tells full from empty when pointers meet.
	wire logic hq_full = full_r[hq];
	wire logic hq_on = wen_r[hq] && q_allowed(hq, ext_sel_r);
	wire logic stage_free = !mem_valid_r || i_mem_wr_ready;
	// The head leaves the FIFO only when the output stage can take it.
	assign head_pop = head_valid && stage_free;
	wire logic enq_ok = head_pop && hq_on && !hq_full;
	wire logic enq_drop = head_pop && !(hq_on && !hq_full);

	////////////////////////////////////////////////////////////////////////////////
	// Dequeue decision.

	wire logic [SQD_CELL_AW-1:0] dq_rp = rp_r[i_deq_queue];
	wire logic dq_empty = (dq_rp == wp_r[i_deq_queue]) && !full_r[i_deq_queue];
	wire logic dq_on = q_allowed(i_deq_queue, ext_sel_r);
	wire logic deq_ok = i_deq_valid && dq_on && !dq_empty;
	wire logic [SQD_CELL_AW-1:0] dq_rp_nxt = step(dq_rp, base_r[i_deq_queue], end_r[i_deq_queue]);

	////////////////////////////////////////////////////////////////////////////////
	// Descriptor storage, one generate slice per queue.

	for (genvar q = 0; q < SQD_NQ; q++) begin : g_q
		wire logic sel = (def_q == 6'(q));

		// Base cell: upper 16 bits and lower 3 bits written separately.
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				base_r[q] <= SQD_PTR_RST;
			end else if (sel && wr_base_hi) begin
				base_r[q][18:3] <= i_wdata;
			end else if (sel && wr_base_lo) begin
				base_r[q][2:0] <= wr_lo_bits;
			end
		end

		// End cell, same split as the base.
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				end_r[q] <= SQD_PTR_RST;
			end else if (sel && wr_end_hi) begin
				end_r[q][18:3] <= i_wdata;
			end else if (sel && wr_end_lo) begin
				end_r[q][2:0] <= wr_lo_bits;
			end
		end

		// Write pointer; a software write wins over a hardware step.
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				wp_r[q] <= SQD_PTR_RST;
			end else if (sel && wr_wp_hi) begin
				wp_r[q][18:3] <= i_wdata;
			end else if (sel && wr_wp_lo) begin
				wp_r[q][2:0] <= wr_lo_bits;
			end else if (enq_ok && (hq == 6'(q))) begin
				wp_r[q] <= hq_wp_nxt;
			end
		end

		// Read pointer; steps on each accepted removal, but a software write in the same cycle wins.
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				rp_r[q] <= SQD_PTR_RST;
			end else if (sel && wr_rp_hi) begin
				rp_r[q][18:3] <= i_wdata;
			end else if (sel && wr_rp_lo) begin
				rp_r[q][2:0] <= wr_lo_bits;
			end else if (deq_ok && (i_deq_queue == 6'(q))) begin
				rp_r[q] <= dq_rp_nxt;
			end
		end

		// Write enable; software is trusted to clear it before reconfiguring.
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				wen_r[q] <= SQD_WEN_RST;
			end else if (i_wr && ctrl_hit && (ctrl_q == 6'(q))) begin
				wen_r[q] <= i_wdata[SQD_WEN_BIT];
			end
		end

		// Full flag: set when a store makes the pointers meet, cleared by a removal.
		// A software pointer load clears it, since reloaded pointers mean an empty ring.
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				full_r[q] <= 1'b0;
			end else if (sel && (wr_wp_hi || wr_wp_lo || wr_rp_hi || wr_rp_lo)) begin
				full_r[q] <= 1'b0;
			end else if (deq_ok && (i_deq_queue == 6'(q))) begin
				full_r[q] <= 1'b0;
			end else if (enq_ok && (hq == 6'(q))) begin
				full_r[q] <= (hq_wp_nxt == rp_r[q]);
			end
		end
	end

	// Extended queue select; default off leaves only the basic group.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ext_sel_r <= SQD_EXT_SEL_RST;
		end else if (i_wr && glob_hit) begin
			ext_sel_r <= i_wdata[SQD_EXT_SEL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output stage toward external memory.

	// Holds one cell write until the memory side takes it.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mem_valid_r <= 1'b0;
			mem_wr_r <= '0;
		end else if (stage_free) begin
			mem_valid_r <= enq_ok;
			mem_wr_r <= enq_ok ? {hq_wp, head.data} : mem_wr_r;
		end
	end

	// Event answers are single-cycle pulses.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			drop_r <= 1'b0;
			deq_valid_r <= 1'b0;
			deq_empty_r <= 1'b0;
			deq_addr_r <= SQD_PTR_RST;
		end else begin
			drop_r <= enq_drop;
			deq_valid_r <= deq_ok;
			deq_empty_r <= i_deq_valid && !deq_ok;
			deq_addr_r <= deq_ok ? dq_rp : deq_addr_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read.

	// Live empty status of the addressed control word.
	wire logic cq_empty = (wp_r[ctrl_q] == rp_r[ctrl_q]) && !full_r[ctrl_q];
	logic [SQD_DW-1:0] rd_nxt;

	// Lower fields sit in bits 15:13; reserved bits and holes read zero.
	always_comb begin
		rd_nxt = 16'h0000;
		if (def_hit) begin
			unique case (def_fld)
				SQD_OFS_BASE_HI: rd_nxt = base_r[def_q][18:3];
				SQD_OFS_BASE_LO: rd_nxt = {base_r[def_q][2:0], 13'h0000};
				SQD_OFS_END_HI: rd_nxt = end_r[def_q][18:3];
				SQD_OFS_END_LO: rd_nxt = {end_r[def_q][2:0], 13'h0000};
				SQD_OFS_WP_HI: rd_nxt = wp_r[def_q][18:3];
				SQD_OFS_WP_LO: rd_nxt = {wp_r[def_q][2:0], 13'h0000};
				SQD_OFS_RP_HI: rd_nxt = rp_r[def_q][18:3];
				SQD_OFS_RP_LO: rd_nxt = {rp_r[def_q][2:0], 13'h0000};
				default: rd_nxt = 16'h0000;
			endcase
		end else if (ctrl_hit) begin
			rd_nxt[SQD_WEN_BIT] = wen_r[ctrl_q];
			rd_nxt[SQD_EMPTY_BIT] = cq_empty;
		end else if (glob_hit) begin
			rd_nxt[SQD_EXT_SEL_BIT] = ext_sel_r;
		end
	end

	// Read data are captured on the strobe and shown in the next cycle only.
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= i_rd ? rd_nxt : 16'h0000;
		end
	end

	assign o_rdata = rdata_r;
	assign o_mem_wr_valid = mem_valid_r;
	assign o_mem_wr = mem_wr_r;
	assign o_cell_drop = drop_r;
	assign o_deq_valid = deq_valid_r;
	assign o_deq_addr = deq_addr_r;
	assign o_deq_empty = deq_empty_r;
endmodule : sqd_queue_descriptor

// file: verif/sqd_mem_model.sv
`timescale 1ns/10ps
// Stand-in for the external cell memory behind the block.
module sqd_mem_model
	import sqd_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_stall,
	input wire logic i_mem_wr_valid,
	output logic o_mem_wr_ready,
	input wire sqd_mem_wr_t i_mem_wr
);
	// Every write taken, in arrival order, kept for the bench to inspect.
	sqd_mem_wr_t taken[$];
	// Ready drops while stalled, so the block must hold its request meanwhile.
	assign o_mem_wr_ready = !i_stall;
	// A write counts only at an edge where valid and ready are both high.
	always @(posedge i_clk) begin
		if (i_mem_wr_valid && o_mem_wr_ready) begin
			taken.push_back(i_mem_wr);
		end
	end
endmodule : sqd_mem_model

// file: verif/sqd_queue_descriptor_monitor.sv
`timescale 1ns/10ps
// Port-level checker; it sees nothing inside the block.
module sqd_queue_descriptor_monitor
	import sqd_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = SQD_FIFO_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic [SQD_AW-1:0] i_addr,
	input wire logic [SQD_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [SQD_DW-1:0] o_rdata,
	input wire logic o_mem_wr_valid,
	input wire logic i_mem_wr_ready,
	input wire sqd_mem_wr_t o_mem_wr,
	input wire logic o_cell_drop,
	input wire logic i_deq_valid,
	input wire logic [5:0] i_deq_queue,
	input wire logic o_deq_valid,
	input wire logic [SQD_CELL_AW-1:0] o_deq_addr,
	input wire logic o_deq_empty
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the extended select, since the checker cannot see the register.
	logic ext_r;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ext_r <= 1'b0;
		end else if (i_wr && i_addr == SQD_GLOBAL_ADDR) begin
			ext_r <= i_wdata[0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) >= 16'h2800 |->
		o_rdata == 16'h0000) else $error("address above the structures read nonzero");
	a_ext_readback: assert property ($past(i_rd) && $past(i_addr) == SQD_GLOBAL_ADDR
		|-> o_rdata == {15'h0000, $past(ext_r)}) else $error("select readback wrong");
	a_ext_block: assert property (i_deq_valid && i_deq_queue[5] && !ext_r
		|=> o_deq_empty && !o_deq_valid) else $error("extended queue served");
	a_deq_answer: assert property (i_deq_valid |=> o_deq_valid ^ o_deq_empty)
		else $error("removal request not answered once");
	a_deq_quiet: assert property (!i_deq_valid |=> !o_deq_valid && !o_deq_empty)
		else $error("removal answer without request");
	a_deq_step: assert property (o_deq_valid && $past(o_deq_valid, 2)
		&& !$past(o_deq_valid) && $past(i_deq_queue, 1) == $past(i_deq_queue, 3) |-> (o_deq_addr ==
		$past(o_deq_addr, 2) + 1 || o_deq_addr < $past(o_deq_addr, 2)))
		else $error("read pointer did not step or wrap");
	a_mem_hold: assert property (o_mem_wr_valid && !i_mem_wr_ready |=>
		o_mem_wr_valid && $stable(o_mem_wr)) else $error("memory write dropped early");
	a_drop_excl: assert property ($rose(o_mem_wr_valid) |-> !o_cell_drop)
		else $error("cell both written and dropped");
	// Main scenarios reached.
	c_drop: cover property (o_cell_drop);
	c_empty: cover property (o_deq_empty);
	c_stall: cover property (o_mem_wr_valid && !i_mem_wr_ready);
endmodule : sqd_queue_descriptor_monitor

bind sqd_queue_descriptor sqd_queue_descriptor_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (.*);

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
	import sqd_pkg::*;
	`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
		$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [15:0] i_addr = '0;
	logic [15:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_cell_valid = 1'b0;
	logic i_deq_valid = 1'b0;
	logic stall = 1'b0;
	sqd_cell_t i_cell = '0;
	logic [5:0] i_deq_queue = '0;
	logic [15:0] o_rdata;
	logic o_cell_ready, o_mem_wr_valid, mem_rdy, o_cell_drop, o_deq_valid, o_deq_empty;
	sqd_mem_wr_t o_mem_wr;
	logic [18:0] o_deq_addr;
	int failures = 0;
	int tests_run = 0;
	int drops = 0;
	sqd_queue_descriptor dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_cell_valid(i_cell_valid), .o_cell_ready(o_cell_ready), .i_cell(i_cell),
		.o_mem_wr_valid(o_mem_wr_valid), .i_mem_wr_ready(mem_rdy), .o_mem_wr(o_mem_wr),
		.o_cell_drop(o_cell_drop), .i_deq_valid(i_deq_valid), .i_deq_queue(i_deq_queue),
		.o_deq_valid(o_deq_valid), .o_deq_addr(o_deq_addr), .o_deq_empty(o_deq_empty));
	sqd_mem_model mem (.i_clk(i_clk), .i_stall(stall), .i_mem_wr_valid(o_mem_wr_valid),
		.o_mem_wr_ready(mem_rdy), .i_mem_wr(o_mem_wr));
	// A 50 MHz clock.
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	// Drop pulses last one cycle, so they are counted at every edge.
	always @(posedge i_clk) begin
		if (o_cell_drop) begin
			drops <= drops + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so it is sampled there.
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 `CHK("rdata", e, o_rdata)
	endtask : rd
	// Software setup: enable low first, pointers loaded with the base, then enable.
	task automatic cfg(input logic [5:0] q, input logic [18:0] b, input logic [18:0] e);
		logic [15:0] s;
		s = SQD_DEF_BASE + {q, 5'h00};
		wr(SQD_CTRL_BASE + {q, 1'b0}, 16'h0000);
		for (int i = 0; i < 16; i += 4) begin
			wr(s + i[15:0], (i == 4) ? e[18:3] : b[18:3]);
			wr(s + i[15:0] + 16'h0002, {(i == 4) ? e[2:0] : b[2:0], 13'h0000});
		end
		wr(SQD_CTRL_BASE + {q, 1'b0}, 16'h0002);
	endtask : cfg
	task automatic enq(input logic [5:0] q, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		i_cell_valid <= 1'b1;
		i_cell <= '{queue: q, data: d};
		for (n = 0; n < 50; n++) begin
			@(negedge i_clk);
			if (o_cell_ready) break;
		end
		@(posedge i_clk);
		i_cell_valid <= 1'b0;
		if (n == 50) begin
			failures++;
			wrap_up();
		end
		repeat (4) @(posedge i_clk);
	endtask : enq
	// The answer stands one cycle after the request is taken.
	task automatic deq(input logic [5:0] q, input logic ok, input logic [18:0] a);
		@(posedge i_clk);
		i_deq_valid <= 1'b1;
		i_deq_queue <= q;
		@(posedge i_clk);
		i_deq_valid <= 1'b0;
		#1 `CHK("deq valid", ok, o_deq_valid)
		`CHK("deq empty", !ok, o_deq_empty)
		if (ok) `CHK("deq addr", a, o_deq_addr)
	endtask : deq
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(SQD_DEF_BASE, 16'h0000);
		rd(SQD_GLOBAL_ADDR, 16'h0000);
		wr(16'h2800, 16'hFFFF);
		rd(16'h2800, 16'h0000);
		rd(16'h27F0, 16'h0000);
	endtask : t_reset
	// Ring of base 10h to end 13h holds four cells; the fifth is refused, then both wrap.
	task automatic t_ring;
		cfg(6'd0, 19'h00010, 19'h00013);
		rd(SQD_DEF_BASE + 16'h0006, 16'h6000);
		for (int i = 0; i < 4; i++) enq(6'd0, 32'hA0 + i);
		`CHK("drops", 0, drops)
		rd(SQD_CTRL_BASE, 16'h0002);
		enq(6'd0, 32'hA4);
		`CHK("drops", 1, drops)
		for (int i = 0; i < 4; i++) deq(6'd0, 1'b1, 19'h00010 + i);
		deq(6'd0, 1'b0, '0);
		rd(SQD_CTRL_BASE, 16'h0802);
		enq(6'd0, 32'hB0);
		deq(6'd0, 1'b1, 19'h00010);
		`CHK("writes", 5, mem.taken.size())
		for (int i = 0; i < 4; i++) `CHK("mem", {19'h00010 + i, 32'hA0 + i}, mem.taken[i])
		`CHK("wrap", {19'h00010, 32'hB0}, mem.taken[4])
	endtask : t_ring
	task automatic t_ext;
		cfg(6'd40, 19'h00100, 19'h00107);
		enq(6'd40, 32'hC0);
		enq(6'd5, 32'hC1);
		`CHK("drops", 3, drops)
		deq(6'd40, 1'b0, '0);
		wr(SQD_GLOBAL_ADDR, 16'h0001);
		rd(SQD_GLOBAL_ADDR, 16'h0001);
		enq(6'd40, 32'hC2);
		`CHK("ext", {19'h00100, 32'hC2}, mem.taken[5])
		deq(6'd40, 1'b1, 19'h00100);
	endtask : t_ext
	// With memory stalled the FIFO and the output stage fill, then drain in order.
	task automatic t_fill;
		int n;
		@(posedge i_clk);
		stall <= 1'b1;
		i_cell_valid <= 1'b1;
		i_cell <= '{queue: 6'd0, data: 32'hD0};
		for (n = 0; n < 40; n++) begin
			@(negedge i_clk);
			if (!o_cell_ready) break;
			@(posedge i_clk);
			i_cell.data <= 32'hD1 + n;
		end
		@(posedge i_clk);
		i_cell_valid <= 1'b0;
		`CHK("accepted", 17, n)
		repeat (5) @(posedge i_clk);
		stall <= 1'b0;
		repeat (60) @(posedge i_clk);
		`CHK("stored", 10, mem.taken.size())
		`CHK("dropped", 16, drops)
	endtask : t_fill
	initial begin
		repeat (10) @(posedge i_clk);
		i_srst <= 1'b0;
		t_reset();
		t_ring();
		t_ext();
		t_fill();
		wrap_up();
	end
endmodule : tb
